// *** ppl_pkg.sv ***
// ppl_pkg: constants shared by the port logic block
// assumes a 16-bit register port and one 100 MHz system clock
package ppl_pkg;
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 8;
  localparam int unsigned OPW = 6;
  // register byte offsets
  localparam logic [7:0] OFS_BIDIR_DATA = 8'h00;
  localparam logic [7:0] OFS_BIDIR_DIR = 8'h04;
  localparam logic [7:0] OFS_BIDIR_MODE = 8'h08;
  localparam logic [7:0] OFS_OUT_DATA = 8'h0C;
  localparam logic [7:0] OFS_CFG_LATCH = 8'h10;
  localparam logic [7:0] OFS_IN_DATA = 8'h14;
  // reset values
  localparam logic [15:0] RST_BIDIR_DATA = 16'h0000;
  localparam logic [15:0] RST_BIDIR_DIR = 16'h0000;
  localparam logic [15:0] RST_BIDIR_MODE = 16'h0000;
  localparam logic [5:0] RST_OUT_DATA = 6'h00;
  localparam logic [15:0] RST_IN_DATA = 16'h0000;
  localparam logic [15:0] IN_PORT_MASK = 16'hC00F;
  // bidir line positions of alternate functions
  localparam int unsigned LN_TW_CLK = 0;
  localparam int unsigned LN_TW_DATA = 1;
  localparam int unsigned LN_CAPTURE = 2;
  localparam int unsigned LN_TOGGLE = 3;
  localparam int unsigned LN_UPDOWN = 4;
  localparam int unsigned LN_CNT_D = 5;
  localparam int unsigned LN_CNT_C = 6;
  localparam int unsigned LN_CNT_B = 7;
  localparam int unsigned LN_MISO = 8;
  localparam int unsigned LN_MOSI = 9;
  localparam int unsigned LN_ATX = 10;
  localparam int unsigned LN_ARX = 11;
  localparam int unsigned LN_SCLK = 13;
  localparam int unsigned LN_NOPIN = 14;
  // start-up config fields
  localparam int unsigned CFG_BOOT = 0;
  localparam int unsigned CFG_CSDIS = 1;
  localparam int unsigned CFG_SEL_LO = 3;
  localparam int unsigned CFG_SEL_HI = 5;
  localparam int unsigned CS_LINE = 5;
  localparam int unsigned SEG_LINES = 5;
  localparam logic [2:0] SEL_BASE = 3'h2;
endpackage

// *** ppl_pin_cell.sv ***
// ppl_pin_cell: drive logic for one line of the bidirectional port
// assumes pad resolves level from out and oe; oe high means driving
`timescale 1ns/1ps
`default_nettype none
module ppl_pin_cell #(
  parameter bit HAS_PIN = 1'b1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic dir,
  input wire logic odm,
  input wire logic data,
  input wire logic alt_act,
  input wire logic alt_val,
  output logic pin_out,
  output logic pin_oe
);
  logic val;
  // alternate output wins over the data bit
  assign val = alt_act ? alt_val : data;

  // registered pad drive; a line without pin never drives
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (clk_en) begin
      if (!HAS_PIN || !dir) begin
        pin_out <= 1'b0;
        pin_oe <= 1'b0;
      end else if (odm) begin
        pin_out <= 1'b0;
        pin_oe <= !val;
      end else begin
        pin_out <= val;
        pin_oe <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** ppl_port_io.sv ***
// ppl_port_io: bidirectional, output and input port logic with registers
// assumes synchronous pins, a one-cycle register port and a bus controller
// supplying segment address and chip select levels
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ppl_port_io (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // bidirectional port pins
  input wire logic [15:0] bidir_port_in,
  output logic [15:0] bidir_port_out,
  output logic [15:0] bidir_port_oe,
  // peripheral outputs toward bidir lines
  input wire logic twowire_clk_line_a_val,
  input wire logic twowire_clk_line_a_act,
  input wire logic twowire_data_line_a_val,
  input wire logic twowire_data_line_a_act,
  input wire logic timer_c_toggle_out_val,
  input wire logic timer_c_toggle_out_act,
  input wire logic sync_serial_miso_val,
  input wire logic sync_serial_miso_act,
  input wire logic sync_serial_mosi_val,
  input wire logic sync_serial_mosi_act,
  input wire logic sync_shift_clk_val,
  input wire logic sync_shift_clk_act,
  input wire logic async_tx_out_val,
  input wire logic async_tx_out_act,
  // pin levels toward peripherals
  output logic twowire_clk_line_a_in,
  output logic twowire_data_line_a_in,
  output logic capture_in,
  output logic timer_c_updown_in,
  output logic timer_d_count_in,
  output logic timer_c_count_in,
  output logic timer_b_count_in,
  output logic sync_serial_miso_in,
  output logic sync_serial_mosi_in,
  output logic sync_shift_clk_in,
  output logic async_rx_in,
  // output port and its alternate sources
  input wire logic [4:0] segment_addr,
  input wire logic third_chip_select,
  input wire logic [5:0] output_port_in,
  output logic [5:0] output_port_out,
  output logic [5:0] output_port_oe,
  output logic boot_loader_enable,
  // input port pins
  input wire logic [15:0] input_port_pins
);
  logic [15:0] bidir_data_reg;
  logic [15:0] bidir_dir_reg;
  logic [15:0] bidir_mode_reg;
  logic [5:0] out_data_reg;
  logic [5:0] cfg_reg;
  logic [15:0] in_data_reg;
  logic [15:0] alt_act;
  logic [15:0] alt_val;
  logic [15:0] rdata_next;
  logic [2:0] seg_sel;
  logic [2:0] seg_cnt;
  logic [5:0] op_next;
  logic wr_en;
  logic rd_en;

  assign wr_en = clk_en && reg_wr;
  assign rd_en = clk_en && reg_rd;

  // bidir port registers; bit 14 kept though it has no pin
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bidir_data_reg <= ppl_pkg::RST_BIDIR_DATA;
      bidir_dir_reg <= ppl_pkg::RST_BIDIR_DIR;
      bidir_mode_reg <= ppl_pkg::RST_BIDIR_MODE;
    end else if (wr_en) begin
      if (reg_addr == ppl_pkg::OFS_BIDIR_DATA) begin
        bidir_data_reg <= reg_wdata;
      end else if (reg_addr == ppl_pkg::OFS_BIDIR_DIR) begin
        bidir_dir_reg <= reg_wdata;
      end else if (reg_addr == ppl_pkg::OFS_BIDIR_MODE) begin
        bidir_mode_reg <= reg_wdata;
      end
    end
  end

  // output port data, six bits wide
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      out_data_reg <= ppl_pkg::RST_OUT_DATA;
    end else if (wr_en && reg_addr == ppl_pkg::OFS_OUT_DATA) begin
      out_data_reg <= reg_wdata[5:0];
    end
  end

  // strap capture: follows the pins every enabled cycle while reset is low,
  // so the last level before release is what stays
  always_ff @(posedge clock) begin
    if (clk_en && !rst_b) begin
      cfg_reg <= output_port_in;
    end
  end

  // boot loader flag from the held strap
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      boot_loader_enable <= 1'b0;
    end else if (clk_en) begin
      boot_loader_enable <= cfg_reg[ppl_pkg::CFG_BOOT];
    end
  end

  // input port sample, unimplemented bits read zero
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      in_data_reg <= ppl_pkg::RST_IN_DATA;
    end else if (clk_en) begin
      in_data_reg <= input_port_pins & ppl_pkg::IN_PORT_MASK;
    end
  end

  // alternate output map of the bidir port
  always_comb begin
    alt_act = 16'h0000;
    alt_val = 16'h0000;
    alt_act[ppl_pkg::LN_TW_CLK] = twowire_clk_line_a_act;
    alt_val[ppl_pkg::LN_TW_CLK] = twowire_clk_line_a_val;
    alt_act[ppl_pkg::LN_TW_DATA] = twowire_data_line_a_act;
    alt_val[ppl_pkg::LN_TW_DATA] = twowire_data_line_a_val;
    alt_act[ppl_pkg::LN_TOGGLE] = timer_c_toggle_out_act;
    alt_val[ppl_pkg::LN_TOGGLE] = timer_c_toggle_out_val;
    alt_act[ppl_pkg::LN_MISO] = sync_serial_miso_act;
    alt_val[ppl_pkg::LN_MISO] = sync_serial_miso_val;
    alt_act[ppl_pkg::LN_MOSI] = sync_serial_mosi_act;
    alt_val[ppl_pkg::LN_MOSI] = sync_serial_mosi_val;
    alt_act[ppl_pkg::LN_SCLK] = sync_shift_clk_act;
    alt_val[ppl_pkg::LN_SCLK] = sync_shift_clk_val;
    alt_act[ppl_pkg::LN_ATX] = async_tx_out_act;
    alt_val[ppl_pkg::LN_ATX] = async_tx_out_val;
  end

  // one drive cell per bidir line; line 14 has no pad
  for (genvar i = 0; i < 16; i++) begin : g_cell
    ppl_pin_cell #(
      .HAS_PIN(i != ppl_pkg::LN_NOPIN)
    ) u_cell (
      .clock(clock),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .dir(bidir_dir_reg[i]),
      .odm(bidir_mode_reg[i]),
      .data(bidir_data_reg[i]),
      .alt_act(alt_act[i]),
      .alt_val(alt_val[i]),
      .pin_out(bidir_port_out[i]),
      .pin_oe(bidir_port_oe[i])
    );
  end

  // pin levels handed to peripherals, registered once
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      twowire_clk_line_a_in <= 1'b1;
      twowire_data_line_a_in <= 1'b1;
      capture_in <= 1'b0;
      timer_c_updown_in <= 1'b0;
      timer_d_count_in <= 1'b0;
      timer_c_count_in <= 1'b0;
      timer_b_count_in <= 1'b0;
      sync_serial_miso_in <= 1'b0;
      sync_serial_mosi_in <= 1'b0;
      sync_shift_clk_in <= 1'b0;
      async_rx_in <= 1'b1;
    end else if (clk_en) begin
      twowire_clk_line_a_in <= bidir_port_in[ppl_pkg::LN_TW_CLK];
      twowire_data_line_a_in <= bidir_port_in[ppl_pkg::LN_TW_DATA];
      capture_in <= bidir_port_in[ppl_pkg::LN_CAPTURE];
      timer_c_updown_in <= bidir_port_in[ppl_pkg::LN_UPDOWN];
      timer_d_count_in <= bidir_port_in[ppl_pkg::LN_CNT_D];
      timer_c_count_in <= bidir_port_in[ppl_pkg::LN_CNT_C];
      timer_b_count_in <= bidir_port_in[ppl_pkg::LN_CNT_B];
      sync_serial_miso_in <= bidir_port_in[ppl_pkg::LN_MISO];
      sync_serial_mosi_in <= bidir_port_in[ppl_pkg::LN_MOSI];
      sync_shift_clk_in <= bidir_port_in[ppl_pkg::LN_SCLK];
      async_rx_in <= bidir_port_in[ppl_pkg::LN_ARX];
    end
  end

  // segment line count: 111 gives five, 011 one, 010 and below none
  assign seg_sel = cfg_reg[ppl_pkg::CFG_SEL_HI:ppl_pkg::CFG_SEL_LO];
  assign seg_cnt = (seg_sel > ppl_pkg::SEL_BASE) ? seg_sel - ppl_pkg::SEL_BASE : 3'h0;

  // output port line select; no software step needed after reset
  always_comb begin
    op_next = out_data_reg;
    for (int k = 0; k < ppl_pkg::SEG_LINES; k++) begin
      if (3'(k) < seg_cnt) begin
        op_next[k] = segment_addr[k];
      end
    end
    if (!cfg_reg[ppl_pkg::CFG_CSDIS]) begin
      op_next[ppl_pkg::CS_LINE] = third_chip_select;
    end
  end

  // output pads float during reset so straps can be read
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      output_port_out <= 6'h00;
      output_port_oe <= 6'h00;
    end else if (clk_en) begin
      output_port_out <= op_next;
      output_port_oe <= 6'h3F;
    end
  end

  // read mux, unmapped reads answer zero
  always_comb begin
    if (reg_addr == ppl_pkg::OFS_BIDIR_DATA) begin
      rdata_next = bidir_data_reg;
    end else if (reg_addr == ppl_pkg::OFS_BIDIR_DIR) begin
      rdata_next = bidir_dir_reg;
    end else if (reg_addr == ppl_pkg::OFS_BIDIR_MODE) begin
      rdata_next = bidir_mode_reg;
    end else if (reg_addr == ppl_pkg::OFS_OUT_DATA) begin
      rdata_next = {10'h000, out_data_reg};
    end else if (reg_addr == ppl_pkg::OFS_CFG_LATCH) begin
      rdata_next = {10'h000, cfg_reg};
    end else if (reg_addr == ppl_pkg::OFS_IN_DATA) begin
      rdata_next = in_data_reg;
    end else begin
      rdata_next = 16'h0000;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= rd_en ? rdata_next : 16'h0000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_push_pull;
    clk_en && bidir_dir_reg[12] && !bidir_mode_reg[12]
      |=> bidir_port_oe[12] && bidir_port_out[12] == $past(bidir_data_reg[12]);
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push/pull line 12 wrong");

  property p_open_drain;
    clk_en && bidir_dir_reg[12] && bidir_mode_reg[12]
      |=> !bidir_port_out[12] && bidir_port_oe[12] == !$past(bidir_data_reg[12]);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain line 12 wrong");

  property p_dir_input;
    clk_en && !bidir_dir_reg[7] |=> !bidir_port_oe[7];
  endproperty
  a_dir_input: assert property (p_dir_input)
    else $error("input line drives");

  property p_no_pin;
    !bidir_port_oe[14] && !bidir_port_out[14];
  endproperty
  a_no_pin: assert property (p_no_pin)
    else $error("line 14 drives");

  property p_alt_tx;
    clk_en && async_tx_out_act && bidir_dir_reg[10] && !bidir_mode_reg[10]
      |=> bidir_port_out[10] == $past(async_tx_out_val);
  endproperty
  a_alt_tx: assert property (p_alt_tx)
    else $error("tx alternate not on line 10");

  property p_strap;
    disable iff (1'b0) clk_en && !rst_b |=> cfg_reg == $past(output_port_in);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap not captured");

  property p_seg_five;
    clk_en && seg_sel == 3'h7 |=> output_port_out[4:0] == $past(segment_addr);
  endproperty
  a_seg_five: assert property (p_seg_five)
    else $error("five segment lines not driven");

  property p_cs_line;
    clk_en && !cfg_reg[1] |=> output_port_out[5] == $past(third_chip_select);
  endproperty
  a_cs_line: assert property (p_cs_line)
    else $error("chip select not on line 5");

  property p_gp_lines;
    clk_en && seg_sel <= 3'h2 && cfg_reg[1] |=> output_port_out == $past(out_data_reg);
  endproperty
  a_gp_lines: assert property (p_gp_lines)
    else $error("general purpose lines wrong");

  property p_auto_oe;
    $rose(rst_b) && clk_en |-> ##1 output_port_oe == 6'h3F;
  endproperty
  a_auto_oe: assert property (p_auto_oe)
    else $error("output port not enabled after reset");

  // pins reach the read data two edges late: one sample stage, one read stage
  property p_in_read;
    rd_en && $past(clk_en) && reg_addr == ppl_pkg::OFS_IN_DATA
      |=> reg_rdata == ($past(input_port_pins, 2) & ppl_pkg::IN_PORT_MASK);
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("input port read wrong");

  // the strap value must not drift once reset is gone
  property p_cfg_hold;
    rst_b |=> $stable(cfg_reg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("start-up config changed at run time");

  property p_rx_line;
    clk_en |=> async_rx_in == $past(bidir_port_in[ppl_pkg::LN_ARX]);
  endproperty
  a_rx_line: assert property (p_rx_line)
    else $error("receive line not from line 11");

  property p_out_width;
    wr_en && reg_addr == ppl_pkg::OFS_OUT_DATA |=> out_data_reg == $past(reg_wdata[5:0]);
  endproperty
  a_out_width: assert property (p_out_width)
    else $error("output port data write lost");

  c_seg_five: cover property (clk_en && seg_sel == 3'h7);
  c_od_release: cover property (bidir_mode_reg[12] && bidir_port_oe[12] == 1'b0 && bidir_dir_reg[12]);
  c_read: cover property (rd_en ##1 reg_rdata != 16'h0000);
  c_cs_line: cover property (clk_en && !cfg_reg[ppl_pkg::CFG_CSDIS] && third_chip_select);
endmodule
`default_nettype wire

// *** ppl_far_side.sv ***
// ppl_far_side: pads and strap resistors seen from outside the port block
// assumes oe high means the block drives the pin; purely combinational
`timescale 1ns/1ps
`default_nettype none
module ppl_far_side (
  input wire logic rst_b,
  input wire logic [5:0] strap,
  input wire logic [15:0] ext_level,
  input wire logic [15:0] bidir_port_out,
  input wire logic [15:0] bidir_port_oe,
  input wire logic [5:0] output_port_out,
  input wire logic [5:0] output_port_oe,
  output logic [15:0] bidir_port_in,
  output logic [5:0] output_port_in
);
  // released bidir lines show the outside level, never the last drive
  assign bidir_port_in = (bidir_port_oe & bidir_port_out) | (~bidir_port_oe & ext_level);
  logic [5:0] op_drive;
  // an enable not yet driven high counts as released, so straps show before the first reset edge
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      op_drive[k] = (output_port_oe[k] === 1'b1);
    end
  end
  // straps held only while reset is low; afterwards the far side flips them so stale samples show
  assign output_port_in = (op_drive & output_port_out) | (~op_drive & (rst_b ? ~strap : strap));
endmodule
`default_nettype wire

// *** tb_top.sv ***
// tb_top: random and corner-case bench for the port logic block
// assumes ppl_far_side resolves the pads; registers reached over the plain port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] alt_act = 16'h0000;
  logic [15:0] alt_val = 16'h0000;
  logic [15:0] ext_level = 16'h0000;
  logic [15:0] pins = 16'h0000;
  logic [4:0] seg = 5'h00;
  logic cs = 1'b0;
  logic en = 1'b1;
  logic [5:0] strap = 6'h00;
  logic [15:0] reg_rdata;
  logic [15:0] bidir_port_in;
  logic [15:0] bidir_port_out;
  logic [15:0] bidir_port_oe;
  logic [5:0] output_port_in;
  logic [5:0] output_port_out;
  logic [5:0] output_port_oe;
  logic boot;
  wire [10:0] per_in;
  logic [31:0] seed = 32'h9F69263A;
  logic [15:0] d, dr, m, o;
  logic [31:0] t, e;
  int bad_count = 0;
  int checked = 0;

  // free-running system clock
  always #5 clock = ~clock;

  ppl_port_io dut (
    .clock(clock), .rst_b(rst_b), .clk_en(en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bidir_port_in(bidir_port_in), .bidir_port_out(bidir_port_out), .bidir_port_oe(bidir_port_oe),
    .twowire_clk_line_a_val(alt_val[0]), .twowire_clk_line_a_act(alt_act[0]),
    .twowire_data_line_a_val(alt_val[1]), .twowire_data_line_a_act(alt_act[1]),
    .timer_c_toggle_out_val(alt_val[3]), .timer_c_toggle_out_act(alt_act[3]),
    .sync_serial_miso_val(alt_val[8]), .sync_serial_miso_act(alt_act[8]),
    .sync_serial_mosi_val(alt_val[9]), .sync_serial_mosi_act(alt_act[9]),
    .sync_shift_clk_val(alt_val[13]), .sync_shift_clk_act(alt_act[13]),
    .async_tx_out_val(alt_val[10]), .async_tx_out_act(alt_act[10]),
    .twowire_clk_line_a_in(per_in[0]), .twowire_data_line_a_in(per_in[1]), .capture_in(per_in[2]),
    .timer_c_updown_in(per_in[3]), .timer_d_count_in(per_in[4]), .timer_c_count_in(per_in[5]),
    .timer_b_count_in(per_in[6]), .sync_serial_miso_in(per_in[7]), .sync_serial_mosi_in(per_in[8]),
    .async_rx_in(per_in[9]), .sync_shift_clk_in(per_in[10]),
    .segment_addr(seg), .third_chip_select(cs), .output_port_in(output_port_in),
    .output_port_out(output_port_out), .output_port_oe(output_port_oe), .boot_loader_enable(boot),
    .input_port_pins(pins)
  );

  ppl_far_side far (
    .rst_b(rst_b), .strap(strap), .ext_level(ext_level),
    .bidir_port_out(bidir_port_out), .bidir_port_oe(bidir_port_oe),
    .output_port_out(output_port_out), .output_port_oe(output_port_oe),
    .bidir_port_in(bidir_port_in), .output_port_in(output_port_in)
  );

  // xorshift source, fixed seed so runs repeat
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // output port: low lines take segment bits, line 5 the chip select unless strapped off
  function automatic logic [5:0] exp_outp(logic [5:0] c, logic [4:0] s, logic x, logic [5:0] dt);
    int n;
    n = (c[5:3] > 3'h2) ? c[5:3] - 2 : 0;
    for (int k = 0; k < 5; k++) exp_outp[k] = (k < n) ? s[k] : dt[k];
    exp_outp[5] = c[1] ? dt[5] : x;
  endfunction

  // bidir pads as {oe, out}; out only meaningful where oe is high
  function automatic logic [31:0] exp_pad(input logic [15:0] dt, dir, md, act, av);
    logic v;
    for (int j = 0; j < 16; j++) begin
      v = act[j] ? av[j] : dt[j];
      exp_pad[16 + j] = dir[j] && j != 14 && !(md[j] && v);
      exp_pad[j] = dir[j] && j != 14 && !md[j] && v;
    end
  endfunction

  task cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // masked so undriven pad values are not judged
  task cmp_pad(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
    checked++;
    if ((got & msk) !== (exp & msk)) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got & msk, exp & msk);
    end
  endtask

  task print_verdict();
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rdc(input logic [7:0] a, input logic [15:0] x);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    cmp_reg(reg_rdata, x);
  endtask

  // watchdog against a hung run
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end

  // one reset per segment selection, then random port traffic
  initial begin
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      t = rnd();
      strap <= {i[2:0], t[2], i[0] ^ i[2], t[0]};
      seg <= t[12:8];
      cs <= t[13];
      pins <= t[31:16];
      rst_b <= 1'b0;
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      #1;
      cmp_pad({15'h0000, boot}, {15'h0000, strap[0]}, 16'hFFFF);
      cmp_pad({10'h000, output_port_oe}, 16'h003F, 16'hFFFF);
      cmp_pad({10'h000, output_port_out}, {10'h000, exp_outp(strap, seg, cs, 6'h00)}, 16'hFFFF);
      for (int a = 0; a < 16; a += 4) rdc(a[7:0], 16'h0000);
      rdc(8'h10, {10'h000, strap});
      rdc(8'h1C, 16'h0000);
      wr(8'h10, 16'hFFFF);
      wr(8'h14, 16'hFFFF);
      rdc(8'h10, {10'h000, strap});
      rdc(8'h14, pins & 16'hC00F);
      for (int r = 0; r < 4; r++) begin
        d = rnd();
        dr = (r < 2) ? 16'hFFFF : rnd();
        m = (r == 0) ? 16'h0000 : (r == 1) ? 16'hFFFF : rnd();
        o = rnd();
        wr(8'h00, d);
        wr(8'h04, dr);
        wr(8'h08, m);
        wr(8'h0C, o);
        t = rnd();
        alt_act <= t[15:0] & 16'h270B;
        alt_val <= t[31:16];
        t = rnd();
        ext_level <= t[15:0];
        pins <= t[31:16];
        seg <= t[4:0];
        cs <= t[5];
        repeat (3) @(posedge clock);
        #1;
        e = exp_pad(d, dr, m, alt_act, alt_val);
        cmp_pad(bidir_port_oe, e[31:16], 16'hFFFF);
        cmp_pad(bidir_port_out, e[15:0], e[31:16]);
        t[15:0] = bidir_port_in;
        cmp_pad({5'h00, per_in}, {5'h00, t[13], t[11], t[9:4], t[2:0]}, 16'hFFFF);
        cmp_pad({10'h000, output_port_out}, {10'h000, exp_outp(strap, seg, cs, o[5:0])}, 16'hFFFF);
        rdc(8'h00, d);
        rdc(8'h04, dr);
        rdc(8'h08, m);
        rdc(8'h0C, o & 16'h003F);
        rdc(8'h14, pins & 16'hC00F);
      end
      // enable low: a write and new alternate levels must not reach the pads
      @(posedge clock);
      en <= 1'b0;
      alt_val <= ~alt_val;
      wr(8'h00, ~d);
      #1;
      cmp_pad(bidir_port_oe, e[31:16], 16'hFFFF);
      cmp_pad(bidir_port_out, e[15:0], e[31:16]);
      @(posedge clock);
      en <= 1'b1;
      rdc(8'h00, d);
      e = exp_pad(d, dr, m, alt_act, alt_val);
      cmp_pad(bidir_port_oe, e[31:16], 16'hFFFF);
      cmp_pad(bidir_port_out, e[15:0], e[31:16]);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
